// ==== svcc_core.sv ====
// Behaviour
// [R1] missing select falling edge within period asserts reset output
// [R2] period bits: 00 1.4 s, 01 600 ms, 10 200 ms, 11 off
// [R3] reset held until supply good continuously for 200 ms
// [R4] serial input shifted into 8-bit opcode on serial clock rise
// [R5] msb first both ways; output changes on serial clock fall
// [R6] select low whole operation; first bit on first rise after fall
// [R7] serial clock may stop anywhere; operation resumes where paused
// [R8] 06h sets write latch; 04h clears latch and reset-cause flag
// [R9] write latch cleared at power-up and after each nonvolatile write
// [R10] 05h returns status at any time, even while busy
// [R11] status: guard, flag, period hi/lo, block hi/lo, latch, busy
// [R12] busy bit read-only, high while nonvolatile write runs
// [R13] 00h sets flag; 04h and power-up clear it
// [R14] 01h writes period, block, guard and flag fields when allowed
// [R15] 03h reads array, 02h writes array, from following address
// [R16] block bits: none, 1800h-1FFFh, 1000h-1FFFh, whole array
// [R17] protected addresses readable, writes rejected
// [R18] guard pin low with guard enable blocks status writes; latch gates all
// [R19] period bits nonvolatile, changed only by status write
// [R20] select high: serial output not driven
// [R21] host sends zeros in status data bits 1 and 0
// [R22] timeouts counted on internal time base, not serial clock
`include "svcc_map.svh"
module svcc_core #(
    parameter int unsigned ADDR_W = 16,
    parameter int unsigned WD_LONG_CYC  = (`SVCC_CLK_HZ / 1000) * `SVCC_WD_LONG_MS,
    parameter int unsigned WD_MID_CYC   = (`SVCC_CLK_HZ / 1000) * `SVCC_WD_MID_MS,
    parameter int unsigned WD_SHORT_CYC = (`SVCC_CLK_HZ / 1000) * `SVCC_WD_SHORT_MS,
    parameter int unsigned HOLD_CYC     = (`SVCC_CLK_HZ / 1000) * `SVCC_HOLD_MS,
    parameter int unsigned NV_WR_CYC    = (`SVCC_CLK_HZ / 1000) * `SVCC_NV_WRITE_MS
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // serial pins (asynchronous to clk_i)
    input  wire logic              select_kick_input_n_i,
    input  wire logic              sck_i,
    input  wire logic              si_i,
    input  wire logic              write_guard_n_i,
    output logic                   so_o,
    output logic                   so_oe_o,
    // supervisor
    input  wire logic              supply_ok_i,
    output logic                   reset_o,
    // array side
    output logic                   arr_rd_o,
    output logic                   arr_wr_o,
    output logic [ADDR_W-1:0]      arr_addr_o,
    output logic [7:0]             arr_wdata_o,
    input  wire logic [7:0]        arr_rdata_i
);
    initial begin
        if (ADDR_W != 16)
            $error("svcc_core: ADDR_W must be 16");
        if (NV_WR_CYC == 0)
            $error("svcc_core: NV_WR_CYC must be nonzero");
    end

    // ==========================================================
    // input synchronisers
    logic [3:0] s1_q, s2_q, s3_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= 4'hf;
            s2_q <= 4'hf;
            s3_q <= 4'hf;
        end else begin
            s1_q <= {select_kick_input_n_i, sck_i, si_i, write_guard_n_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    logic cs_n, cs_fall, cs_rise, sck_rise, sck_fall, si, guard_pin_n;
    assign cs_n        = s2_q[3];
    assign cs_fall     = s3_q[3] & ~s2_q[3];
    assign cs_rise     = ~s3_q[3] & s2_q[3];
    assign sck_rise    = ~s3_q[2] & s2_q[2];
    assign sck_fall    = s3_q[2] & ~s2_q[2];
    assign si          = s2_q[1];
    assign guard_pin_n = s2_q[0];

    function automatic logic blk_protected(input logic [1:0] blk, input logic [15:0] a);
        unique case (blk)
            2'b00: blk_protected = 1'b0;
            2'b01: blk_protected = (a[12:0] >= `SVCC_PROT_QTR); // [R16]
            2'b10: blk_protected = (a[12:0] >= `SVCC_PROT_HALF);
            2'b11: blk_protected = (a[12:0] >= `SVCC_PROT_ALL);
        endcase
    endfunction : blk_protected

    // ==========================================================
    // serial state
    svcc_pkg::svcc_phase_t ph_q, ph_d;
    logic [7:0]  sh_q, sh_d, op_q, op_d, out_q, out_d, wdat_q, wdat_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [15:0] addr_q, addr_d;
    logic        so_q, so_d, oe_q, oe_d, rd_q, rd_d;
    logic        pend_q, pend_d, full_q, full_d, first_q, first_d;
    // nonvolatile and volatile status
    logic        guard_q, guard_d, flag_q, flag_d, arm_q, arm_d;
    logic [1:0]  per_q, per_d, blk_q, blk_d;
    logic [31:0] busy_q, busy_d;
    logic        nvst_q, nvst_d, nvarr_q, nvarr_d, wr_q, wr_d;
    logic [7:0]  nvval_q, nvval_d;
    logic [7:0]  status;
    logic [7:0]  nxt_byte;
    logic        stat_ok, arr_ok;

    assign status = {guard_q, flag_q, per_q, blk_q, arm_q, busy_q != 32'h0}; // [R11] [R12]
    assign nxt_byte = {sh_q[6:0], si};
    assign arr_ok = arm_q && !blk_protected(blk_q, addr_q); // [R17]
    assign stat_ok = arm_q && !(guard_q && !guard_pin_n); // [R18]

    always_comb begin
        ph_d = ph_q; sh_d = sh_q; op_d = op_q; out_d = out_q; wdat_d = wdat_q;
        cnt_d = cnt_q; addr_d = addr_q; so_d = so_q; oe_d = oe_q; rd_d = 1'b0;
        pend_d = pend_q; full_d = full_q; first_d = first_q;
        guard_d = guard_q; flag_d = flag_q; arm_d = arm_q; per_d = per_q;
        blk_d = blk_q; busy_d = busy_q; nvst_d = nvst_q; nvarr_d = nvarr_q;
        wr_d = 1'b0; nvval_d = nvval_q;

        if (busy_q != 32'h0) begin
            busy_d = busy_q - 32'h1;
            if (busy_q == 32'h1) begin
                arm_d = 1'b0; // [R9]
                if (nvst_q) begin
                    // period bits change only here  [R19]
                    guard_d = nvval_q[`SVCC_ST_GUARD];
                    flag_d  = nvval_q[`SVCC_ST_FLAG];
                    per_d   = nvval_q[`SVCC_ST_PER_HI:`SVCC_ST_PER_LO];
                    blk_d   = nvval_q[`SVCC_ST_BLK_HI:`SVCC_ST_BLK_LO];
                end
                nvst_d = 1'b0;
                nvarr_d = 1'b0;
            end
        end

        if (cs_n) begin
            // [R20]
            oe_d = 1'b0;
            ph_d = svcc_pkg::SVCC_IDLE;
            // commit only when select rises on a byte boundary
            if (cs_rise && pend_q && cnt_q == 5'd0 && busy_q == 32'h0) begin
                if (op_q == `SVCC_OP_STAT_WR) begin
                    nvst_d = 1'b1;
                    nvval_d = wdat_q;
                end else begin
                    nvarr_d = 1'b1;
                end
                busy_d = NV_WR_CYC;
            end
            pend_d = 1'b0;
        end else begin
            if (cs_fall) begin
                ph_d = svcc_pkg::SVCC_OPCODE; // [R6]
                cnt_d = 5'd0;
                first_d = 1'b1;
                oe_d = 1'b1;
            end
            // stalled serial clock simply leaves state untouched  [R7]
            if (sck_rise && ph_q != svcc_pkg::SVCC_IDLE) begin
                sh_d = nxt_byte; // [R4] [R5]
                cnt_d = cnt_q + 5'd1;
                unique case (ph_q)
                    svcc_pkg::SVCC_OPCODE: if (cnt_q == 5'd7) begin
                        op_d = nxt_byte;
                        cnt_d = 5'd0;
                        ph_d = svcc_pkg::SVCC_IGNORE;
                        unique case (nxt_byte)
                            `SVCC_OP_ARM: if (busy_q == 32'h0) arm_d = 1'b1; // [R8]
                            `SVCC_OP_DISARM: if (busy_q == 32'h0) begin
                                arm_d = 1'b0; // [R8] [R13]
                                flag_d = 1'b0;
                            end
                            `SVCC_OP_SET_FLAG: flag_d = 1'b1; // [R13]
                            `SVCC_OP_STAT_RD: begin
                                out_d = status; // [R10]
                                ph_d = svcc_pkg::SVCC_STAT_OUT;
                            end
                            `SVCC_OP_STAT_WR: if (busy_q == 32'h0) begin
                                ph_d = svcc_pkg::SVCC_DATA; // [R14]
                            end
                            `SVCC_OP_ARR_RD, `SVCC_OP_ARR_WR: if (busy_q == 32'h0) begin
                                ph_d = svcc_pkg::SVCC_ADDR; // [R15]
                            end
                            default: ph_d = svcc_pkg::SVCC_IGNORE;
                        endcase
                    end
                    svcc_pkg::SVCC_ADDR: begin
                        addr_d = {addr_q[14:0], si};
                        if (cnt_q == 5'd15) begin
                            cnt_d = 5'd0;
                            ph_d = svcc_pkg::SVCC_DATA;
                            if (op_q == `SVCC_OP_ARR_RD) rd_d = 1'b1;
                        end
                    end
                    svcc_pkg::SVCC_DATA: if (cnt_q[2:0] == 3'd7) begin
                        cnt_d = 5'd0;
                        if (op_q == `SVCC_OP_STAT_WR) begin
                            // host keeps bits 1..0 zero  [R21]
                            wdat_d = nxt_byte;
                            pend_d = stat_ok; // [R18]
                            ph_d = svcc_pkg::SVCC_IGNORE;
                        end else if (op_q == `SVCC_OP_ARR_WR) begin
                            wdat_d = nxt_byte;
                            wr_d = arr_ok; // [R17] [R18]
                            pend_d = pend_q | arr_ok;
                            addr_d = {addr_q[15:5], addr_q[4:0] + 5'd1};
                        end else begin
                            addr_d = addr_q + 16'h1;
                            rd_d = 1'b1;
                        end
                    end
                    svcc_pkg::SVCC_STAT_OUT: if (cnt_q[2:0] == 3'd7) begin
                        cnt_d = 5'd0;
                        out_d = status;
                    end
                    default: cnt_d = 5'd0;
                endcase
                if (ph_q == svcc_pkg::SVCC_DATA && op_q == `SVCC_OP_ARR_WR
                    && cnt_q[2:0] != 3'd7) pend_d = 1'b0;
            end
            if (rd_q) out_d = arr_rdata_i;
            if (sck_fall) begin
                // [R5]
                if (ph_q == svcc_pkg::SVCC_STAT_OUT
                    || (ph_q == svcc_pkg::SVCC_DATA && op_q == `SVCC_OP_ARR_RD)) begin
                    so_d = out_q[3'd7 - cnt_q[2:0]];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_q <= svcc_pkg::SVCC_IDLE;
            sh_q <= 8'h00; op_q <= 8'hff; out_q <= 8'h00; wdat_q <= 8'h00;
            cnt_q <= 5'd0; addr_q <= 16'h0000; so_q <= 1'b0; oe_q <= 1'b0;
            rd_q <= 1'b0; pend_q <= 1'b0; full_q <= 1'b0; first_q <= 1'b0;
            guard_q <= 1'b0; flag_q <= 1'b0; arm_q <= 1'b0; // [R9] [R13]
            per_q <= 2'b00; blk_q <= 2'b00; busy_q <= 32'h0;
            nvst_q <= 1'b0; nvarr_q <= 1'b0; wr_q <= 1'b0; nvval_q <= 8'h00;
        end else begin
            ph_q <= ph_d; sh_q <= sh_d; op_q <= op_d; out_q <= out_d;
            wdat_q <= wdat_d; cnt_q <= cnt_d; addr_q <= addr_d; so_q <= so_d;
            oe_q <= oe_d; rd_q <= rd_d; pend_q <= pend_d; full_q <= full_d;
            first_q <= first_d; guard_q <= guard_d; flag_q <= flag_d;
            arm_q <= arm_d; per_q <= per_d; blk_q <= blk_d; busy_q <= busy_d;
            nvst_q <= nvst_d; nvarr_q <= nvarr_d; wr_q <= wr_d; nvval_q <= nvval_d;
        end
    end

    // ==========================================================
    // watchdog and supply hold
    logic rst_w, rst_q2;
    svcc_timer #(
        .WD_LONG  (WD_LONG_CYC),
        .WD_MID   (WD_MID_CYC),
        .WD_SHORT (WD_SHORT_CYC),
        .HOLD     (HOLD_CYC)
    ) u_timer (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .kick_i      (cs_fall), // [R1]
        .period_i    (per_q),
        .supply_ok_i (supply_ok_i),
        .reset_o     (rst_w)
    );
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rst_q2 <= 1'b1;
        else rst_q2 <= rst_w;
    end

    assign reset_o     = rst_q2;
    assign so_o        = so_q;
    assign so_oe_o     = oe_q;
    assign arr_rd_o    = rd_q;
    assign arr_wr_o    = wr_q;
    assign arr_addr_o  = addr_q;
    assign arr_wdata_o = wdat_q;
endmodule : svcc_core

// ==== svcc_map.svh ====
`ifndef SVCC_MAP_SVH
`define SVCC_MAP_SVH
// ==========================================================
// opcodes
`define SVCC_OP_ARM        8'h06
`define SVCC_OP_SET_FLAG   8'h00
`define SVCC_OP_DISARM     8'h04
`define SVCC_OP_STAT_RD    8'h05
`define SVCC_OP_STAT_WR    8'h01
`define SVCC_OP_ARR_RD     8'h03
`define SVCC_OP_ARR_WR     8'h02
// ==========================================================
// status field positions
`define SVCC_ST_GUARD      7
`define SVCC_ST_FLAG       6
`define SVCC_ST_PER_HI     5
`define SVCC_ST_PER_LO     4
`define SVCC_ST_BLK_HI     3
`define SVCC_ST_BLK_LO     2
`define SVCC_ST_ARM        1
`define SVCC_ST_BUSY       0
// ==========================================================
// protected range starts
`define SVCC_PROT_QTR      16'h1800
`define SVCC_PROT_HALF     16'h1000
`define SVCC_PROT_ALL      16'h0000
// ==========================================================
// timing, in ms, and clock rate
`define SVCC_CLK_HZ        10000000
`define SVCC_WD_LONG_MS    1400
`define SVCC_WD_MID_MS     600
`define SVCC_WD_SHORT_MS   200
`define SVCC_HOLD_MS       200
`define SVCC_NV_WRITE_MS   5
`endif

// ==== svcc_pkg.sv ====
package svcc_pkg;
    typedef enum logic [2:0] {
        SVCC_IDLE,
        SVCC_OPCODE,
        SVCC_ADDR,
        SVCC_DATA,
        SVCC_STAT_OUT,
        SVCC_IGNORE
    } svcc_phase_t;
endpackage : svcc_pkg

// ==== svcc_timer.sv ====
`include "svcc_map.svh"
module svcc_timer #(
    parameter int unsigned WD_LONG  = 14000000,
    parameter int unsigned WD_MID   = 6000000,
    parameter int unsigned WD_SHORT = 2000000,
    parameter int unsigned HOLD     = 2000000
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // control
    input  wire logic       kick_i,
    input  wire logic [1:0] period_i,
    input  wire logic       supply_ok_i,
    // result
    output logic            reset_o
);
    initial begin
        if (WD_LONG == 0 || WD_MID == 0 || WD_SHORT == 0 || HOLD == 0)
            $error("svcc_timer: counts must be nonzero");
    end

    logic [31:0] wd_q, wd_d, hold_q, hold_d;
    logic        rst_q, rst_d;
    logic [31:0] limit;

    always_comb begin
        unique case (period_i)
            2'b00: limit = WD_LONG;
            2'b01: limit = WD_MID;
            2'b10: limit = WD_SHORT;
            2'b11: limit = 32'h0;
        endcase
        wd_d   = wd_q;
        hold_d = hold_q;
        rst_d  = rst_q;
        // free-running time base, independent of the serial clock  [R22]
        if (kick_i || period_i == 2'b11 || rst_q) begin
            wd_d = 32'h0;
        end else if (wd_q + 32'h1 >= limit) begin
            wd_d  = 32'h0;
            rst_d = 1'b1; // [R1]
        end else begin
            wd_d = wd_q + 32'h1; // [R2]
        end
        if (!supply_ok_i) begin
            hold_d = 32'h0;
            rst_d  = 1'b1;
        end else if (rst_q) begin
            // supply must stay good for the whole hold  [R3]
            if (hold_q + 32'h1 >= HOLD) begin
                hold_d = 32'h0;
                rst_d  = 1'b0;
            end else begin
                hold_d = hold_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd_q   <= 32'h0;
            hold_q <= 32'h0;
            rst_q  <= 1'b1;
        end else begin
            wd_q   <= wd_d;
            hold_q <= hold_d;
            rst_q  <= rst_d;
        end
    end

    assign reset_o = rst_q;
endmodule : svcc_timer

// ==== svcc_core_sva.sv ====
module svcc_core_sva #(
    parameter int unsigned WD_SHORT_CYC = 2000000,
    parameter int unsigned HOLD_CYC     = 2000000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // watched pins
    input wire logic select_kick_input_n_i,
    input wire logic sck_i,
    input wire logic supply_ok_i,
    input logic      so_o,
    input logic      so_oe_o,
    input logic      reset_o,
    input logic      arr_rd_o,
    input logic      arr_wr_o
);
    localparam int unsigned HOLD_MIN = HOLD_CYC - 1;
    localparam int unsigned WD_MIN   = WD_SHORT_CYC - 1;
    // ==========================================================
    // helper counters: supply good run, cycles since last kick
    int unsigned ok_cnt_q, ok_cnt_d, idle_cnt_q, idle_cnt_d;
    logic        sel_q;
    always_comb begin
        ok_cnt_d   = supply_ok_i ? ((ok_cnt_q < 32'h00ffffff) ? ok_cnt_q + 1 : ok_cnt_q) : 0;
        idle_cnt_d = (sel_q && !select_kick_input_n_i) ? 0 :
                     ((idle_cnt_q < 32'h00ffffff) ? idle_cnt_q + 1 : idle_cnt_q);
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ok_cnt_q   <= 0;
            idle_cnt_q <= 0;
            sel_q      <= 1'b1;
        end else begin
            ok_cnt_q   <= ok_cnt_d;
            idle_cnt_q <= idle_cnt_d;
            sel_q      <= select_kick_input_n_i;
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_oe_on_select: assert property ($fell(select_kick_input_n_i) |-> ##[1:4] so_oe_o)
        else $error("so_oe_o not raised after select");
    chk_oe_off_idle: assert property (select_kick_input_n_i [*4] |-> !so_oe_o)
        else $error("so_oe_o high while deselected");
    chk_so_on_fall: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o) |-> !sck_i)
        else $error("so_o changed while sck high");
    chk_supply_drop: assert property (!supply_ok_i |-> ##[0:4] reset_o)
        else $error("reset_o not raised on low supply");
    chk_reset_holds: assert property (reset_o && !supply_ok_i |=> reset_o)
        else $error("reset_o dropped with low supply");
    chk_hold_time: assert property ($fell(reset_o) |-> ok_cnt_q >= HOLD_MIN)
        else $error("reset_o released before hold time");
    chk_wd_bite_late: assert property (
        $rose(reset_o) && supply_ok_i && $past(supply_ok_i, 8) |-> idle_cnt_q >= WD_MIN)
        else $error("watchdog reset before shortest period");
    chk_rd_selected: assert property (arr_rd_o |-> !$past(select_kick_input_n_i, 3))
        else $error("array read while deselected");
    chk_req_one_cycle: assert property (arr_rd_o || arr_wr_o |=> !(arr_rd_o || arr_wr_o))
        else $error("array request longer than one cycle");
    cover_release: cover property ($fell(reset_o));
    cover_write: cover property (arr_wr_o);
    cover_read: cover property (arr_rd_o);
endmodule : svcc_core_sva

// ==== svcc_host.sv ====
module svcc_host #(
    parameter int HALF = 7
) (
    // serial pins
    input  wire logic clk_i,
    output logic      sel_n_o,
    output logic      sck_o,
    output logic      si_o,
    input  wire logic so_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sel_n_o = 1'b1;
        sck_o   = 1'b0;
        si_o    = 1'b0;
    end
    // ==========================================================
    // one framed transfer, msb first; clock may pause after bit gap
    task automatic frame(input int nbits, input logic [39:0] mosi, input int gap,
                         output logic [39:0] miso);
        miso = '0;
        @(posedge clk_i);
        sel_n_o <= 1'b0;
        repeat (HALF) @(posedge clk_i);
        for (int i = nbits - 1; i >= 0; i--) begin
            si_o <= mosi[i];
            repeat (HALF) @(posedge clk_i);
            miso = {miso[38:0], so_i};
            sck_o <= 1'b1;
            repeat (HALF) @(posedge clk_i);
            sck_o <= 1'b0;
            if (i == gap) repeat (400) @(posedge clk_i);
        end
        repeat (HALF) @(posedge clk_i);
        sel_n_o <= 1'b1;
        si_o    <= ~si_o;
        repeat (2 * HALF) @(posedge clk_i);
    endtask : frame
    task automatic kick();
        @(posedge clk_i);
        sel_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        sel_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask : kick
endmodule : svcc_host

// ==== svcc_core_tb_top.sv ====
`include "svcc_map.svh"
module svcc_core_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned HOLD    = 300;
    localparam int unsigned WD_T[4] = '{2000, 1000, 500, 0};
    logic        clk_i, rst_n_i, sel_n, sck, si, guard_n, so, so_oe, supply_ok, rst_out;
    logic        arr_rd, arr_wr;
    logic [15:0] arr_addr, wr_addr, rd_addr;
    logic [7:0]  arr_wdata, arr_rdata, wr_data, st;
    logic [39:0] rx;
    int          n_mismatch = 0, check_count = 0, wr_count = 0, rd_seen = 0;
    logic [7:0]  ops[6]  = '{`SVCC_OP_ARM, `SVCC_OP_SET_FLAG, `SVCC_OP_DISARM,
                             `SVCC_OP_SET_FLAG, `SVCC_OP_ARM, `SVCC_OP_DISARM};
    logic [7:0]  exps[6] = '{8'h02, 8'h42, 8'h00, 8'h40, 8'h42, 8'h00};
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    svcc_core #(.WD_LONG_CYC(2000), .WD_MID_CYC(1000), .WD_SHORT_CYC(500),
        .HOLD_CYC(HOLD), .NV_WR_CYC(300)) u_svcc_core (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .select_kick_input_n_i(sel_n), .sck_i(sck),
        .si_i(si), .write_guard_n_i(guard_n), .so_o(so), .so_oe_o(so_oe),
        .supply_ok_i(supply_ok), .reset_o(rst_out), .arr_rd_o(arr_rd), .arr_wr_o(arr_wr),
        .arr_addr_o(arr_addr), .arr_wdata_o(arr_wdata), .arr_rdata_i(arr_rdata));
    svcc_host u_svcc_host (.clk_i(clk_i), .sel_n_o(sel_n), .sck_o(sck), .si_o(si), .so_i(so));
    always @(posedge clk_i) begin
        if (arr_wr) begin
            wr_count <= wr_count + 1;
            wr_addr  <= arr_addr;
            wr_data  <= arr_wdata;
        end
        if (arr_rd && rd_seen == 0) rd_addr <= arr_addr;
        if (arr_rd) rd_seen <= rd_seen + 1;
    end
    // ==========================================================
    // checking and bus helpers
    function automatic logic prot(input logic [1:0] bl, input logic [15:0] a);
        return (bl == 2'b11) || (bl == 2'b10 && a >= 16'h1000) || (bl == 2'b01 && a >= 16'h1800);
    endfunction : prot
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic wait_low(input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk_i);
            if (rst_out === 1'b0) return;
        end
        n_mismatch++;
        $display("wrong value reset_o expected 0 seen %b", rst_out);
        report_and_stop();
    endtask : wait_low
    task automatic xfer(input int nbits, input logic [39:0] mosi);
        u_svcc_host.frame(nbits, mosi, -1, rx);
        chk_val("so enable idle", 16'h0, {15'h0, so_oe});
    endtask : xfer
    task automatic rd_stat(output logic [7:0] s);
        xfer(16, {24'h0, `SVCC_OP_STAT_RD, 8'h00});
        s = rx[7:0];
    endtask : rd_stat
    task automatic wait_idle(output logic [7:0] s);
        for (int i = 0; i < 10; i++) begin
            rd_stat(s);
            if (s[0] === 1'b0) return;
        end
        n_mismatch++;
        $display("wrong value busy expected 0 seen %b", s[0]);
        report_and_stop();
    endtask : wait_idle
    task automatic wr_stat(input logic [7:0] v);
        xfer(8, {32'h0, `SVCC_OP_ARM});
        xfer(16, {24'h0, `SVCC_OP_STAT_WR, v});
        wait_idle(st);
    endtask : wr_stat
    // ==========================================================
    // main sequence
    initial begin
        logic [1:0]  bl;
        logic [15:0] a;
        logic [7:0]  d, v;
        int          n;
        rst_n_i = 1'b0;
        guard_n = 1'b1;
        supply_ok = 1'b1;
        arr_rdata = 8'h00;
        void'($urandom(32'hc5ec));
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (HOLD - 10) @(posedge clk_i);
        chk_val("reset hold", 16'h1, {15'h0, rst_out});
        wait_low(40);
        rd_stat(st);
        chk_val("status after reset", 16'h0, {8'h0, st});
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            xfer(8, {32'h0, ops[i]});
            rd_stat(st);
            chk_val("status after command", {8'h0, exps[i]}, {8'h0, st});
        end
        u_svcc_host.frame(16, {24'h0, `SVCC_OP_STAT_RD, 8'h00}, 11, rx);
        chk_val("status after stall", 16'h0, {8'h0, rx[7:0]});
        xfer(16, {24'h0, `SVCC_OP_STAT_WR, 8'h3c});
        rd_stat(st);
        chk_val("write without arm", 16'h0, {8'h0, st});
        xfer(8, {32'h0, `SVCC_OP_ARM});
        xfer(16, {24'h0, `SVCC_OP_STAT_WR, 8'h3c});
        rd_stat(st);
        chk_val("busy bit", 16'h1, {15'h0, st[0]});
        wait_idle(st);
        chk_val("status written", 16'h3c, {8'h0, st});
        $display("test commands done");
        for (int k = 0; k < 6; k++) begin
            bl = 2'($urandom_range(0, 3));
            a  = 16'($urandom_range(0, 16'h1fff));
            d  = 8'($urandom);
            if (k < 2) bl = 2'b01;
            if (k < 2) a = (k == 0) ? 16'h17ff : 16'h1800;
            v  = {1'b0, 1'($urandom), 2'($urandom), bl, 2'b00};
            wr_stat(v);
            chk_val("status readback", {8'h0, v}, {8'h0, st});
            n = wr_count;
            xfer(8, {32'h0, `SVCC_OP_ARM});
            xfer(32, {8'h0, `SVCC_OP_ARR_WR, a, d});
            wait_idle(st);
            chk_val("write accepted", {15'h0, !prot(bl, a)}, 16'(wr_count - n));
            if (!prot(bl, a)) chk_val("write address", {a[15:5], a[4:0] + 5'd1}, wr_addr);
            if (!prot(bl, a)) chk_val("write data", {8'h0, d}, {8'h0, wr_data});
            arr_rdata <= d ^ 8'h5a;
            rd_seen = 0;
            xfer(32, {8'h0, `SVCC_OP_ARR_RD, a, 8'h00});
            chk_val("read address", a, rd_addr);
            chk_val("read data", {8'h0, d ^ 8'h5a}, {8'h0, rx[7:0]});
        end
        $display("test protection done");
        wr_stat(8'h80);
        guard_n <= 1'b0;
        xfer(8, {32'h0, `SVCC_OP_ARM});
        xfer(16, {24'h0, `SVCC_OP_STAT_WR, 8'h0c});
        rd_stat(st);
        chk_val("guarded write", 16'h82, {8'h0, st});
        guard_n <= 1'b1;
        wr_stat(8'h00);
        chk_val("guard released", 16'h0, {8'h0, st});
        n = wr_count;
        xfer(32, {8'h0, `SVCC_OP_ARR_WR, 16'h0010, 8'ha5});
        rd_stat(st);
        chk_val("unarmed array write", 16'h0, 16'(wr_count - n));
        $display("test guard done");
        for (int p = 0; p < 4; p++) begin
            wr_stat({2'b00, 2'(p), 4'h0});
            wait_low(4 * HOLD);
            u_svcc_host.kick();
            n = 0;
            while (rst_out !== 1'b1 && n < 2600) begin
                @(posedge clk_i);
                n++;
            end
            if (p == 3) chk_val("watchdog off", 16'h0, {15'h0, rst_out});
            else chk_val("watchdog period", 16'h1, {15'h0, n + 16 >= WD_T[p] && n <= WD_T[p] + 8});
        end
        $display("test watchdog done");
        supply_ok <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk_val("supply low reset", 16'h1, {15'h0, rst_out});
        supply_ok <= 1'b1;
        repeat (100) @(posedge clk_i);
        supply_ok <= 1'b0;
        repeat (2) @(posedge clk_i);
        supply_ok <= 1'b1;
        repeat (HOLD - 10) @(posedge clk_i);
        chk_val("supply glitch hold", 16'h1, {15'h0, rst_out});
        wait_low(40);
        $display("test supply done");
        report_and_stop();
    end
endmodule : svcc_core_tb_top
bind svcc_core svcc_core_sva #(.WD_SHORT_CYC(WD_SHORT_CYC), .HOLD_CYC(HOLD_CYC)) u_svcc_core_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .select_kick_input_n_i(select_kick_input_n_i),
    .sck_i(sck_i), .supply_ok_i(supply_ok_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .reset_o(reset_o), .arr_rd_o(arr_rd_o), .arr_wr_o(arr_wr_o));
